// [rtl/phy_control_status_regs.v]
/*
 Management control word,
 status word and duplex
 status of one port, with
 low-power, isolate and
 collision-test gating of
 the MAC side and restart.
 Assumes core events arrive
 synchronous to clock, and
 control bits 15:12 are
 held elsewhere by the
 core.
*/
`timescale 1ns/1ns
`include "phy_regs_defs.vh"

// Behaviour
// - low power stops core, MAC outputs low
// - low power floats twisted-pair transmit outputs
// - low-power entry resets only latching status bits
// - isolate floats MAC outputs, ignores MAC inputs
// - isolate resets to one at address zero
// - restart write ignored with negotiation disabled
// - restart bit starts negotiation, self-clears
// - hardware mode takes duplex from pin
// - detail register shows active-link duplex in hardware mode, duplex_mode otherwise
// - software duplex from negotiation or control bit
// - loopback makes duplex control bit ineffective
// - collision test off, COL not from transmit
// - collision test drives COL from transmit enable
// - control reserved bits read zero
// - status resets to defaults, index one
// - four-pair capability always reads zero
// - capability bits 14:11 reset one, 10:7 reset zero, override-writable
// - negotiation-complete latches high, resets zero
// - fault, jabber latch high; link latches low
// - negotiation ability and extended capability read one
// - override writes blocked unless enable set
module phy_control_status_regs (
   input wire clock, // 20 MHz system clock
   input wire resetn, // async reset, active low
   input wire mdc, // management clock, sampled
   input wire mdio_in, // management data in
   output wire mdio_out, // management data out
   output wire mdio_oe, // high while driving mdio
   input wire [4:0] phy_address, // strapped management address
   input wire config_source_pin, // 0 hardware, 1 software mode
   input wire duplex_select_pin, // hardware-mode duplex
   input wire reset_bit, // control bit 15, held elsewhere
   input wire loopback_bit, // control bit 14, held elsewhere
   input wire rate_bit, // control bit 13, held elsewhere
   input wire an_enable_bit, // control bit 12, held elsewhere
   input wire override_write_en, // extended control bit 15
   input wire an_started, // pulse: negotiation has begun
   input wire an_complete, // level: negotiation done
   input wire an_result_full, // negotiated full duplex
   input wire remote_fault_in, // remote fault received
   input wire jabber_in, // jabber condition
   input wire link_up, // link valid
   input wire link_full, // active link is full duplex
   output reg an_restart, // pulse: restart negotiation
   output reg duplex_mode, // 1 full, 0 half
   output wire core_enable, // internal functions running
   output wire tx_pair_tristate, // float the transmit pair
   input wire [3:0] txd_in, // MAC transmit data
   input wire tx_en_in, // MAC transmit enable
   input wire tx_er_in, // MAC transmit error
   output wire [3:0] core_txd, // gated transmit data
   output wire core_tx_en, // gated transmit enable
   output wire core_tx_er, // gated transmit error
   input wire [8:0] core_mac_out, // core MAC-side outputs but COL
   input wire core_col, // core collision detect
   output wire [8:0] mac_out, // MAC-side outputs but COL
   output wire mac_out_oe, // high while MAC side driven
   output reg col_out, // collision to MAC
   output wire col_oe // high while COL driven
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg low_power_reg;
   reg isolate_reg;
   reg strap_done_reg;
   reg restart_reg;
   reg duplex_bit_reg;
   reg col_test_reg;

   reg [7:0] ovr_reg;
   reg an_done_lh_reg;
   reg rfault_lh_reg;
   reg jabber_lh_reg;
   reg link_ll_reg;

   wire [4:0] reg_addr;
   wire [15:0] wdata;
   wire wr_stb;
   wire rd_stb;
   reg [15:0] rdata;

   wire ctl_wr;
   wire st_wr;
   wire st_rd;
   wire lp_enter;

   wire an_done_ev;
   wire hw_mode;
   wire tx_en_g;

   reg duplex_next;

   // ----------------------------------------
   // shared helpers
   // ----------------------------------------

   // latching-high update: a read recaptures, an event sets unless the clear is asserted
   function lh_update;
      input held;
      input event_in;
      input rd;
      input clr;

      begin
         if (clr)
            lh_update = 1'b0;
         else
            lh_update = (rd ? 1'b0 : held) | event_in;
      end
   endfunction

   function is_reg;
      input [4:0] addr;
      input [4:0] want;

      begin
         is_reg = (addr == want);
      end
   endfunction

   // ----------------------------------------
   // serial management access
   // ----------------------------------------
   mgmt_frame_engine frame_engine (
      .clock(clock),
      .resetn(resetn),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe),
      .phy_address(phy_address),
      .reg_addr(reg_addr),
      .wdata(wdata),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rdata(rdata)
   );

   assign ctl_wr = wr_stb & is_reg(reg_addr, `REG_CONTROL);

   assign st_wr = wr_stb & is_reg(reg_addr, `REG_STATUS);

   assign st_rd = rd_stb & is_reg(reg_addr, `REG_STATUS);

   assign hw_mode = ~config_source_pin;

   assign lp_enter = ctl_wr & wdata[`CTL_LOW_POWER] & ~low_power_reg;

   // ----------------------------------------
   // control word
   // ----------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         low_power_reg <= 1'b0;
         isolate_reg <= 1'b1;
         strap_done_reg <= 1'b0;
         duplex_bit_reg <= 1'b0;
         col_test_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;

         // strap is caught on the first edge after release
         if (!strap_done_reg)
            isolate_reg <= (phy_address == 5'h00);
         else if (ctl_wr)
            isolate_reg <= wdata[`CTL_ISOLATE];

         if (ctl_wr) begin
            low_power_reg <= wdata[`CTL_LOW_POWER];
            duplex_bit_reg <= wdata[`CTL_DUPLEX];
            col_test_reg <= wdata[`CTL_COL_TEST];
         end
      end
   end

   // ----------------------------------------
   // negotiation restart
   // ----------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         restart_reg <= 1'b0;
         an_restart <= 1'b0;
      end else begin
         an_restart <= 1'b0;

         if (ctl_wr && wdata[`CTL_RESTART] && an_enable_bit) begin
            restart_reg <= 1'b1;
            an_restart <= 1'b1;
         end else if (an_started || !an_enable_bit) begin
            restart_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // duplex selection
   // ----------------------------------------
   always @* begin
      if (hw_mode)
         duplex_next = duplex_select_pin;
      else if (an_enable_bit)
         duplex_next = an_result_full;
      else if (loopback_bit)
         duplex_next = 1'b0;
      else
         duplex_next = duplex_bit_reg;
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         duplex_mode <= 1'b0;
      else
         duplex_mode <= duplex_next;
   end

   // ----------------------------------------
   // status word
   // ----------------------------------------

   // completion only counts while negotiation is enabled
   assign an_done_ev = an_complete & an_enable_bit & ~low_power_reg;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ovr_reg <= `ST_OVR_RESET;
         an_done_lh_reg <= 1'b0;
         rfault_lh_reg <= 1'b0;
         jabber_lh_reg <= 1'b0;
         link_ll_reg <= 1'b0;
      end else begin
         if (st_wr && override_write_en)
            ovr_reg <= wdata[`ST_OVR_HI:`ST_OVR_LO];

         an_done_lh_reg <= lh_update(an_done_lh_reg, an_done_ev, st_rd, lp_enter);

         rfault_lh_reg <= lh_update(rfault_lh_reg, remote_fault_in & ~low_power_reg,
                                    st_rd, lp_enter);

         jabber_lh_reg <= lh_update(jabber_lh_reg, jabber_in & ~low_power_reg,
                                    st_rd, lp_enter);

         // latching low: a loss always clears, a read recaptures the level
         if (lp_enter)
            link_ll_reg <= 1'b0;
         else
            link_ll_reg <= (st_rd ? 1'b1 : link_ll_reg) & link_up & ~low_power_reg;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always @* begin
      rdata = 16'h0000;

      if (is_reg(reg_addr, `REG_CONTROL)) begin
         rdata[`CTL_RESET] = reset_bit;
         rdata[`CTL_LOOPBACK] = loopback_bit;
         rdata[`CTL_RATE] = rate_bit;
         rdata[`CTL_AN_EN] = an_enable_bit;
         rdata[`CTL_LOW_POWER] = low_power_reg;
         rdata[`CTL_ISOLATE] = isolate_reg;
         rdata[`CTL_RESTART] = restart_reg;
         // in hardware mode the stored bit is meaningless; show the pin
         rdata[`CTL_DUPLEX] = hw_mode ? duplex_select_pin : duplex_bit_reg;
         rdata[`CTL_COL_TEST] = col_test_reg; // bits below stay zero

      end else if (is_reg(reg_addr, `REG_STATUS)) begin
         rdata[`ST_T4] = 1'b0;
         rdata[`ST_OVR_HI:`ST_OVR_LO] = ovr_reg;
         rdata[`ST_PREAMBLE] = 1'b0;
         rdata[`ST_AN_DONE] = an_done_lh_reg;
         rdata[`ST_RFAULT] = rfault_lh_reg;
         rdata[`ST_AN_ABLE] = 1'b1;
         rdata[`ST_LINK] = link_ll_reg;
         rdata[`ST_JABBER] = jabber_lh_reg;
         rdata[`ST_EXT_CAP] = 1'b1;

      end else if (is_reg(reg_addr, `REG_DETAIL)) begin
         rdata[`DET_DUPLEX] = hw_mode ? link_full : duplex_mode;
      end
   end

   // ----------------------------------------
   // power and MAC-side gating
   // ----------------------------------------
   assign core_enable = ~low_power_reg;
   assign tx_pair_tristate = low_power_reg;

   // pass-through path is combinational: MAC clocks cannot ride a flop
   assign mac_out = (low_power_reg | isolate_reg) ? 9'h000 : core_mac_out;

   assign mac_out_oe = ~isolate_reg;
   assign col_oe = ~isolate_reg;

   assign tx_en_g = tx_en_in & ~isolate_reg & ~low_power_reg;
   assign core_tx_en = tx_en_g;

   assign core_txd = (isolate_reg | low_power_reg) ? 4'h0 : txd_in;
   assign core_tx_er = tx_er_in & ~isolate_reg & ~low_power_reg;

   // ----------------------------------------
   // collision
   // ----------------------------------------

   // one flop stage keeps COL inside the assert budget; its 50 ns cycle exceeds the 40 ns release budget
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         col_out <= 1'b0;
      else if (low_power_reg | isolate_reg)
         col_out <= 1'b0;
      else if (col_test_reg)
         col_out <= tx_en_g;
      else
         col_out <= core_col & ~loopback_bit;
   end

endmodule

// [rtl/phy_regs_defs.vh]
/*
 Register indices, fields, reset values, timing.
 Assumes one 20 MHz clock.
*/
`ifndef PHY_REGS_DEFS_VH
`define PHY_REGS_DEFS_VH

// --------------------
// register indices
// --------------------
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h01
`define REG_DETAIL 5'h11

// --------------------
// control word fields
// --------------------
`define CTL_RESET 15
`define CTL_LOOPBACK 14
`define CTL_RATE 13
`define CTL_AN_EN 12
`define CTL_LOW_POWER 11
`define CTL_ISOLATE 10
`define CTL_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7

// --------------------
// status and detail word fields
// --------------------
`define ST_T4 15
`define ST_OVR_HI 14
`define ST_OVR_LO 7
`define ST_PREAMBLE 6
`define ST_AN_DONE 5
`define ST_RFAULT 4
`define ST_AN_ABLE 3
`define ST_LINK 2
`define ST_JABBER 1
`define ST_EXT_CAP 0
`define ST_OVR_RESET 8'hf0
`define DET_DUPLEX 14

// --------------------
// timing
// --------------------
`define CLK_PERIOD_NS 50
`define BIT_TIME_NS 10
`define COL_ON_MAX_NS (512 * `BIT_TIME_NS)
`define COL_OFF_MAX_NS (4 * `BIT_TIME_NS)
`define COL_ON_CYC (`COL_ON_MAX_NS / `CLK_PERIOD_NS)
`define COL_OFF_CYC ((`COL_OFF_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`COL_OFF_MAX_NS / `CLK_PERIOD_NS))

// --------------------
// serial frame
// --------------------
`define PREAMBLE_LEN 6'd32
`define OP_READ 2'b10
`define OP_WRITE 2'b01

`endif

// [rtl/mgmt_frame_engine.v]
/*
 Management frame engine: one frame, one register strobe.
 Assumes mdc sync to clock and below a quarter of its rate.
*/
`timescale 1ns/1ns
`include "phy_regs_defs.vh"

module mgmt_frame_engine (
   input wire clock, // system clock
   input wire resetn, // async reset, active low
   input wire mdc, // management clock, sampled
   input wire mdio_in, // management data in
   output reg mdio_out, // management data out
   output reg mdio_oe, // high while driving data
   input wire [4:0] phy_address, // strapped address
   output reg [4:0] reg_addr, // register index
   output reg [15:0] wdata, // write data
   output reg wr_stb, // one-cycle write strobe
   output reg rd_stb, // one-cycle read strobe
   input wire [15:0] rdata // read data, valid with rd_stb
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam S_PRE = 2'd0;
   localparam S_HDR = 2'd1;
   localparam S_TA = 2'd2;
   localparam S_DATA = 2'd3;

   reg [1:0] state_reg;
   reg [5:0] pre_cnt_reg;
   reg [3:0] cnt_reg;
   reg [12:0] hdr_reg;
   reg [15:0] sh_reg;
   reg rd_active_reg;
   reg mdc_reg;
   wire rise;
   wire fall;
   wire [13:0] hdr_full;

   assign rise = mdc & ~mdc_reg;
   assign fall = ~mdc & mdc_reg;
   assign hdr_full = {hdr_reg, mdio_in};

   // ----------------------------------------
   // frame decode on rising mdc
   // ----------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= S_PRE;
         pre_cnt_reg <= 6'd0;
         cnt_reg <= 4'd0;
         hdr_reg <= 13'h0000;
         sh_reg <= 16'h0000;
         rd_active_reg <= 1'b0;
         mdc_reg <= 1'b0;
         reg_addr <= 5'h00;
         wdata <= 16'h0000;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
      end else begin
         mdc_reg <= mdc;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (rd_stb)
            sh_reg <= rdata;
         if (rise) begin
            case (state_reg)
               S_PRE: begin
                  if (mdio_in) begin
                     if (pre_cnt_reg != `PREAMBLE_LEN)
                        pre_cnt_reg <= pre_cnt_reg + 6'd1;
                  end else if (pre_cnt_reg == `PREAMBLE_LEN) begin
                     hdr_reg <= 13'h0000;
                     cnt_reg <= 4'd1;
                     state_reg <= S_HDR;
                  end else begin
                     pre_cnt_reg <= 6'd0;
                  end
               end
               S_HDR: begin
                  hdr_reg <= hdr_full[12:0];
                  cnt_reg <= cnt_reg + 4'd1;
                  if (cnt_reg == 4'd13) begin
                     cnt_reg <= 4'd0;
                     pre_cnt_reg <= 6'd0;
                     reg_addr <= hdr_full[4:0];
                     // frames for other addresses are dropped silently
                     if (hdr_full[13:12] == 2'b01 && hdr_full[9:5] == phy_address &&
                         (hdr_full[11:10] == `OP_READ || hdr_full[11:10] == `OP_WRITE)) begin
                        rd_active_reg <= (hdr_full[11:10] == `OP_READ);
                        rd_stb <= (hdr_full[11:10] == `OP_READ);
                        state_reg <= S_TA;
                     end else begin
                        state_reg <= S_PRE;
                     end
                  end
               end
               S_TA: begin
                  cnt_reg <= cnt_reg + 4'd1;
                  if (cnt_reg == 4'd1) begin
                     cnt_reg <= 4'd0;
                     state_reg <= S_DATA;
                  end
               end
               S_DATA: begin
                  if (!rd_active_reg)
                     sh_reg <= {sh_reg[14:0], mdio_in};
                  cnt_reg <= cnt_reg + 4'd1;
                  if (cnt_reg == 4'd15) begin
                     if (!rd_active_reg) begin
                        wdata <= {sh_reg[14:0], mdio_in};
                        wr_stb <= 1'b1;
                     end
                     rd_active_reg <= 1'b0;
                     state_reg <= S_PRE;
                  end
               end
               default: state_reg <= S_PRE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // read data driven on falling mdc
   // ----------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (fall) begin
         mdio_oe <= rd_active_reg && ((state_reg == S_TA && cnt_reg == 4'd1) || state_reg == S_DATA);
         if (state_reg == S_DATA)
            mdio_out <= sh_reg[4'd15 - cnt_reg];
         else
            mdio_out <= 1'b0;
      end else if (rise && state_reg == S_DATA && cnt_reg == 4'd15) begin
         mdio_oe <= 1'b0;
      end
   end

endmodule

// [verif/phy_regs_checker_sva.sv]
/*
 Checker: power, isolate, duplex and restart rules.
 Assumes binding to the top module's ports.
*/
`timescale 1ns/1ns

module phy_regs_checker (
   input wire clock, // clock
   input wire resetn, // reset, low
   input wire config_source_pin, // mode pin
   input wire duplex_select_pin, // duplex pin
   input wire loopback_bit, // loopback
   input wire an_enable_bit, // negotiation on
   input wire an_result_full, // negotiated duplex
   input wire an_restart, // restart pulse
   input wire duplex_mode, // duplex used
   input wire core_enable, // core on
   input wire tx_pair_tristate, // pair float
   input wire tx_en_in, // MAC enable
   input wire core_tx_en, // gated enable
   input wire [3:0] core_txd, // gated data
   input wire [8:0] core_mac_out, // core outputs
   input wire [8:0] mac_out, // MAC outputs
   input wire mac_out_oe, // MAC driven
   input wire col_oe // COL driven
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // --------------------
   // assertions
   // --------------------
   property p_lp_tri; core_enable != tx_pair_tristate; endproperty
   a_lp_tri: assert property (p_lp_tri) else $error("pair float vs core");
   property p_lp_mac; !core_enable |-> mac_out == 9'h000 && core_txd == 4'h0 && !core_tx_en; endproperty
   a_lp_mac: assert property (p_lp_mac) else $error("MAC active in low power");
   property p_iso_out; !mac_out_oe |-> mac_out == 9'h000 && core_txd == 4'h0 && !core_tx_en; endproperty
   a_iso_out: assert property (p_iso_out) else $error("isolated data passed");
   property p_iso_col; col_oe == mac_out_oe; endproperty
   a_iso_col: assert property (p_iso_col) else $error("COL enable mismatch");
   property p_pass; mac_out_oe && core_enable |-> mac_out == core_mac_out && core_tx_en == tx_en_in; endproperty
   a_pass: assert property (p_pass) else $error("MAC side not passed");
   property p_hw_dpx;
      (!config_source_pin && $stable(duplex_select_pin)) [*2] |-> duplex_mode == duplex_select_pin;
   endproperty
   a_hw_dpx: assert property (p_hw_dpx) else $error("duplex not from pin");
   property p_sw_dpx;
      (config_source_pin && an_enable_bit && !loopback_bit && $stable(an_result_full)) [*2]
         |-> duplex_mode == an_result_full;
   endproperty
   a_sw_dpx: assert property (p_sw_dpx) else $error("duplex not negotiated");
   property p_rst_gate; an_restart |-> $past(an_enable_bit) ##1 !an_restart; endproperty
   a_rst_gate: assert property (p_rst_gate) else $error("restart while disabled");
   c_low_power: cover property (!core_enable);
   c_restart: cover property (an_restart);
   c_isolate: cover property (!mac_out_oe);
endmodule

bind phy_control_status_regs phy_regs_checker chk (.clock, .resetn, .config_source_pin, .duplex_select_pin,
   .loopback_bit, .an_enable_bit, .an_result_full, .an_restart, .duplex_mode, .core_enable, .tx_pair_tristate,
   .tx_en_in, .core_tx_en, .core_txd, .core_mac_out, .mac_out, .mac_out_oe, .col_oe);

// [verif/mgmt_station.sv]
/*
 Station model: full-preamble frames on mdc and mdio.
 Assumes released mdio pulls up; samples before mdc rises.
*/
`timescale 1ns/1ns

module mgmt_station (
   input wire clock, // system clock
   input wire [4:0] phy_address, // target address
   input wire mdio_wire, // resolved mdio level
   output reg mdc, // management clock, idle low
   output reg m_drv, // station data
   output reg m_en // high while station drives
);
   initial begin
      mdc = 1'b0;
      m_drv = 1'b1;
      m_en = 1'b0;
   end
   // four clocks a half period keeps mdc under a quarter of the clock
   task half;
      begin
         repeat (4) @(posedge clock);
         #1;
      end
   endtask
   task frame(input logic [1:0] op, input logic [4:0] r, input logic [15:0] wd, output logic [15:0] rd);
      logic [45:0] hdr;
      logic [15:0] wv;
      integer i;
      begin
         wv = (r == 5'h00) ? {wd[15:7], 7'h00} : wd;
         hdr = {32'hffffffff, 2'b01, op, phy_address, r};
         rd = 16'h0000;
         for (i = 0; i < 64; i = i + 1) begin
            m_en = (op == 2'b01) || (i < 46);
            m_drv = (i < 46) ? hdr[45 - i] : ((i < 48) ? (i == 46) : wv[63 - i]);
            half;
            if (i >= 48)
               rd[63 - i] = mdio_wire;
            mdc = 1'b1;
            half;
            mdc = 1'b0;
         end
         m_en = 1'b0;
      end
   endtask
endmodule

// [verif/tb.sv]
/*
 Bench: register access via the station model, pin and event stimulus.
 Assumes the station model and checker compile alongside.
*/
`timescale 1ns/1ns
`include "phy_regs_defs.vh"

module tb;
   reg clock, resetn, config_source_pin, duplex_select_pin, reset_bit, loopback_bit, rate_bit, an_enable_bit;
   reg override_write_en, an_started, an_complete, an_result_full, remote_fault_in, jabber_in, link_up, link_full;
   reg [4:0] phy_address;
   reg tx_en_in, tx_er_in, core_col, lp, iso, dpx, ct;
   reg [8:0] core_mac_out;
   reg [15:0] v;
   wire mdio_out, mdio_oe, m_drv, m_en, mdc, an_restart, duplex_mode, core_enable, tx_pair_tristate;
   wire core_tx_en, core_tx_er, mac_out_oe, col_out, col_oe, mdio_wire;
   wire [3:0] core_txd;
   wire [8:0] mac_out;
   integer err_total = 0;
   integer cmp_count = 0;
   integer cycles = 0;
   integer pulses = 0;
   integer k;
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   // a released line is pulled up
   assign mdio_wire = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);
   phy_control_status_regs uut (.clock, .resetn, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe, .phy_address,
      .config_source_pin, .duplex_select_pin, .reset_bit, .loopback_bit, .rate_bit, .an_enable_bit,
      .override_write_en, .an_started, .an_complete, .an_result_full, .remote_fault_in, .jabber_in, .link_up,
      .link_full, .an_restart, .duplex_mode, .core_enable, .tx_pair_tristate, .txd_in(4'h5), .tx_en_in,
      .tx_er_in, .core_txd, .core_tx_en, .core_tx_er, .core_mac_out, .core_col, .mac_out, .mac_out_oe,
      .col_out, .col_oe);
   mgmt_station sme (.clock, .phy_address, .mdio_wire, .mdc, .m_drv, .m_en);
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge clock) begin
      cycles = cycles + 1;
      if (an_restart === 1'b1)
         pulses = pulses + 1;
      if (cycles == 40000) begin
         err_total = err_total + 1;
         summarize;
      end
   end
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   task rd(input logic [4:0] r);
      begin
         sme.frame(`OP_READ, r, 16'h0000, v);
         cyc(2);
      end
   endtask
   task wr(input logic [4:0] r, input logic [15:0] d);
      begin
         sme.frame(`OP_WRITE, r, d, v);
         cyc(2);
      end
   endtask
   function [15:0] ctl(input logic rs);
      ctl = {reset_bit, loopback_bit, rate_bit, an_enable_bit, lp, iso, rs, dpx, ct, 7'h00};
   endfunction
   task stat(input logic [15:0] e);
      begin
         rd(`REG_STATUS);
         check("status", v, e);
      end
   endtask
   task ctl_chk(input logic rs);
      begin
         rd(`REG_CONTROL);
         check("control", v, ctl(rs));
      end
   endtask
   task do_reset(input logic [4:0] a);
      begin
         resetn = 0;
         phy_address = a;
         {lp, dpx, ct} = 3'b000;
         iso = (a == 5'h00);
         cyc(12);
         resetn = 1;
         cyc(2);
      end
   endtask
   initial begin
      {config_source_pin, duplex_select_pin, reset_bit, loopback_bit, an_enable_bit, rate_bit} = 6'b100001;
      {override_write_en, an_started, an_complete, an_result_full} = 4'h0;
      {remote_fault_in, jabber_in, link_up, link_full} = 4'h0;
      {tx_en_in, tx_er_in, core_col} = 3'b000;
      core_mac_out = 9'h1a5;
      do_reset(5'h00);
      check("isolate oe", mac_out_oe, 1'b0);
      ctl_chk(0);
      stat(16'h7809);
      rd(5'h1f);
      check("unmapped", v, 16'h0000);
      do_reset(5'h01);
      check("isolate oe", mac_out_oe, 1'b1);
      $display("test reset done");
      wr(`REG_STATUS, 16'h0000);
      stat(16'h7809);
      override_write_en = 1;
      wr(`REG_STATUS, 16'h0480);
      stat(16'h0489);
      override_write_en = 0;
      $display("test override done");
      {an_enable_bit, an_complete, link_up, jabber_in, remote_fault_in} = 5'h1f;
      cyc(1);
      {jabber_in, remote_fault_in} = 2'b00;
      stat(16'h04bb);
      stat(16'h04ad);
      link_up = 0;
      cyc(1);
      link_up = 1;
      stat(16'h04a9);
      stat(16'h04ad);
      $display("test latching done");
      {an_complete, link_up, jabber_in, tx_en_in, tx_er_in} = 5'h07;
      cyc(1);
      jabber_in = 0;
      lp = 1;
      wr(`REG_CONTROL, ctl(0));
      check("core enable", core_enable, 1'b0);
      check("pair float", tx_pair_tristate, 1'b1);
      check("mac out", {mac_out, core_txd, core_tx_er}, 14'h0000);
      stat(16'h0489);
      ctl_chk(0);
      lp = 0;
      wr(`REG_CONTROL, ctl(0));
      check("core enable", core_enable, 1'b1);
      check("pair float", tx_pair_tristate, 1'b0);
      check("mac out", {mac_out, core_txd, core_tx_er}, {core_mac_out, 5'h0b});
      {tx_en_in, tx_er_in} = 2'b00;
      $display("test low power done");
      an_enable_bit = 0;
      k = pulses;
      wr(`REG_CONTROL, ctl(1));
      check("restart count", 16'(pulses - k), 16'h0000);
      ctl_chk(0);
      an_enable_bit = 1;
      wr(`REG_CONTROL, ctl(1));
      check("restart count", 16'(pulses - k), 16'h0001);
      ctl_chk(1);
      an_started = 1;
      cyc(1);
      an_started = 0;
      ctl_chk(0);
      $display("test restart done");
      an_enable_bit = 0;
      for (k = 0; k < 2; k = k + 1) begin
         dpx = k[0];
         wr(`REG_CONTROL, ctl(0));
         check("duplex", duplex_mode, dpx);
      end
      loopback_bit = 1;
      cyc(3);
      check("duplex", duplex_mode, 1'b0);
      {loopback_bit, an_enable_bit} = 2'b01;
      for (k = 1; k >= 0; k = k - 1) begin
         an_result_full = k[0];
         cyc(3);
         check("duplex", duplex_mode, k[0]);
      end
      config_source_pin = 0;
      for (k = 0; k < 2; k = k + 1) begin
         {duplex_select_pin, link_full} = {k[0], k[0]};
         cyc(3);
         check("duplex", duplex_mode, k[0]);
         rd(`REG_DETAIL);
         check("detail", v, {1'b0, k[0], 14'h0000});
      end
      config_source_pin = 1;
      $display("test duplex done");
      tx_en_in = 1;
      cyc(3);
      check("collision", col_out, 1'b0);
      {tx_en_in, loopback_bit, ct} = 3'b011;
      wr(`REG_CONTROL, ctl(0));
      tx_en_in = 1;
      for (k = 0; k < `COL_ON_CYC && col_out !== 1'b1; k = k + 1)
         cyc(1);
      check("collision", col_out, 1'b1);
      tx_en_in = 0;
      cyc(`COL_OFF_CYC);
      check("collision", col_out, 1'b0);
      $display("test collision done");
      summarize;
   end
endmodule
